// ---- hw/ebd_call_engine.sv ----
/*
  ebd_call_engine: hardware call engine beside the ethernet mac; copy,
  fill, inter-buffer dma, tx start, tx buffer grant, tx result queue.
  assumes: mac events and loader port are on sys_clk; caller waits for
  callDone before the next call.
*/
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module ebd_call_engine (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // call link
  ebd_call_if.dev link,
  // mac side events
  input wire logic txResValid,
  input wire logic [7:0] txResId,
  input wire logic [7:0] txResCode,
  input wire logic mgmtDoneIn,
  input wire logic pauseDoneIn,
  input wire logic txBufRelease,
  // memory loader and peek port
  input wire logic memLoadEn,
  input wire logic [6:0] memLoadAddr,
  input wire logic [31:0] memLoadData,
  input wire logic [6:0] memPeekAddr,
  output logic [31:0] memPeekData,
  // tx dma start towards mac
  output logic txStart,
  output logic [11:0] txLen
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MOVE = 2'b10
  } ebd_dev_state_t;

  typedef struct packed {
    ebd_dev_state_t st;
    logic [7:0] src;
    logic [7:0] dst;
    logic [12:0] cnt;
    logic [31:0] pat;
    logic fill;
    logic ib;
    logic ready;
    logic done;
    logic [31:0] stat;
    logic [31:0] sec;
    logic txStart;
    logic [11:0] txLen;
    logic [2:0] bufUsed;
    logic [3:0][15:0] q;
    logic [1:0] rp;
    logic [1:0] wp;
    logic [2:0] qCnt;
    logic [4:0] irq;
    logic [31:0] peek;
  } ebd_dev_s_t;

  ebd_dev_s_t s_r, s_nxt;
  logic [31:0] mem [ebd_pkg::MEM_WORDS];
  logic memWe;
  logic [6:0] memAddr;
  logic [31:0] memWd;

  // return word: code in low bits, done flag on every non-error code
  function automatic logic [31:0] ansWord(input logic [1:0] code);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[1:0] = code;
    w[ebd_pkg::DONE_BIT] = ~code[1];
    return w;
  endfunction

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    logic [31:0] len;
    logic [13:0] srcEnd, dstEnd;
    logic doPop, popOk, bufGet, bufPut;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.txStart = 1'b0;
    s_nxt.irq = 5'h00;
    len = link.callArg[2];
    srcEnd = {7'h00, link.callArg[0][6:0]} + len[13:0];
    dstEnd = {7'h00, link.callArg[1][6:0]} + len[13:0];
    doPop = 1'b0;
    popOk = 1'b0;
    bufGet = 1'b0;
    bufPut = txBufRelease && s_r.bufUsed != 3'h0;
    memWe = 1'b0;
    memAddr = s_r.dst[6:0];
    memWd = s_r.fill ? s_r.pat : mem[s_r.src[6:0]];
    // other events pass straight through as one-cycle pulses
    s_nxt.irq[1] = mgmtDoneIn;
    s_nxt.irq[2] = pauseDoneIn;
    s_nxt.peek = mem[memPeekAddr];
    case (s_r.st)
      ST_IDLE: begin
        if (link.callValid && s_r.ready) begin
          s_nxt.src = {1'b0, link.callArg[0][6:0]};
          s_nxt.dst = {1'b0, link.callArg[1][6:0]};
          s_nxt.cnt = len[12:0];
          s_nxt.pat = link.callArg[3];
          s_nxt.fill = 1'b0;
          s_nxt.ib = 1'b0;
          s_nxt.sec = 32'h0000_0000;
          s_nxt.stat = ansWord(ebd_pkg::RC_INVALID);
          s_nxt.done = 1'b1;
          case (link.callFunc)
            ebd_pkg::FN_TX_START: begin
              if (len >= ebd_pkg::TX_MIN_BYTES && len <= ebd_pkg::TX_MAX_BYTES) begin
                s_nxt.txStart = 1'b1;
                s_nxt.txLen = len[11:0];
                s_nxt.stat = ansWord(ebd_pkg::RC_OK);
              end
            end
            ebd_pkg::FN_COPY: begin
              // same region on both sides is refused up front
              if (s_nxt.src[ebd_pkg::BUF_SEL_BIT] != s_nxt.dst[ebd_pkg::BUF_SEL_BIT] &&
                  len != 32'h0000_0000 && len[31:8] == 24'h00_0000 &&
                  srcEnd <= ebd_pkg::MEM_END && dstEnd <= ebd_pkg::MEM_END) begin
                s_nxt.done = 1'b0;
                s_nxt.ready = 1'b0;
                s_nxt.st = ST_MOVE;
              end
            end
            ebd_pkg::FN_FILL: begin
              // short fills are refused; long ones would wrap the end sum
              if (len >= ebd_pkg::FILL_MIN_WORDS && len[31:8] == 24'h00_0000 &&
                  dstEnd <= ebd_pkg::MEM_END) begin
                s_nxt.fill = 1'b1;
                s_nxt.done = 1'b0;
                s_nxt.ready = 1'b0;
                s_nxt.st = ST_MOVE;
              end
            end
            ebd_pkg::FN_IBDMA: begin
              // no range check: running off the end aborts with error
              if (s_nxt.src[ebd_pkg::BUF_SEL_BIT] == s_nxt.dst[ebd_pkg::BUF_SEL_BIT] &&
                  len != 32'h0000_0000 && len[31:13] == 19'h0_0000) begin
                s_nxt.ib = 1'b1;
                s_nxt.stat = ansWord(ebd_pkg::RC_OK);
                s_nxt.ready = 1'b0;
                s_nxt.st = ST_MOVE;
              end
            end
            ebd_pkg::FN_TXBUF: begin
              if (s_r.bufUsed == ebd_pkg::TXBUF_COUNT && !bufPut) begin
                s_nxt.stat = ansWord(ebd_pkg::RC_NOBUF);
              end else begin
                bufGet = 1'b1;
                s_nxt.stat = ansWord(ebd_pkg::RC_OK);
                s_nxt.sec = ebd_pkg::TXBUF_BASE +
                  32'(32'(s_r.bufUsed - 3'(bufPut)) * ebd_pkg::TXBUF_BYTES);
              end
            end
            ebd_pkg::FN_TXRES: begin
              doPop = 1'b1;
              s_nxt.stat = ansWord(ebd_pkg::RC_OK);
              s_nxt.sec = (s_r.qCnt != 3'h0) ? {16'h0000, s_r.q[s_r.rp]} : 32'h0000_0000;
            end
            default: begin
              s_nxt.stat = ansWord(ebd_pkg::RC_INVALID);
            end
          endcase
        end
      end
      ST_MOVE: begin
        if (s_r.src[7] || s_r.dst[7]) begin
          // the inter-buffer path, and a fill through its unchecked src, can run past the end
          s_nxt.irq[4] = 1'b1;
          s_nxt.ready = 1'b1;
          s_nxt.st = ST_IDLE;
        end else begin
          memWe = 1'b1;
          s_nxt.src = s_r.src + 8'h01;
          s_nxt.dst = s_r.dst + 8'h01;
          s_nxt.cnt = s_r.cnt - 13'h0001;
          if (s_r.cnt == 13'h0001) begin
            s_nxt.ready = 1'b1;
            s_nxt.st = ST_IDLE;
            if (s_r.ib) begin
              s_nxt.irq[3] = 1'b1;
            end else begin
              s_nxt.done = 1'b1;
              s_nxt.stat = ansWord(ebd_pkg::RC_OK);
            end
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
        s_nxt.ready = 1'b1;
      end
    endcase
    // loader writes only while the engine leaves the memory alone
    if (!memWe && memLoadEn) begin
      memWe = 1'b1;
      memAddr = memLoadAddr;
      memWd = memLoadData;
    end
    s_nxt.bufUsed = s_r.bufUsed + 3'(bufGet) - 3'(bufPut);
    // result queue: a push into a full queue drops the oldest entry
    popOk = doPop && s_r.qCnt != 3'h0;
    if (popOk) begin
      s_nxt.rp = s_r.rp + 2'h1;
    end
    if (txResValid) begin
      s_nxt.q[s_r.wp] = {txResId, txResCode};
      s_nxt.wp = s_r.wp + 2'h1;
      if (s_r.qCnt == ebd_pkg::TXQ_DEPTH && !popOk) begin
        s_nxt.rp = s_r.rp + 2'h1;
        s_nxt.irq[0] = 1'b1;
      end else begin
        s_nxt.qCnt = s_r.qCnt + 3'h1 - 3'(popOk);
      end
    end else begin
      s_nxt.qCnt = s_r.qCnt - 3'(popOk);
    end
    if (doPop) begin
      s_nxt.stat[ebd_pkg::PEND_BIT] = s_nxt.qCnt != 3'h0;
    end
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // word store, no reset: contents are undefined until loaded
  always_ff @(posedge sys_clk) begin
    if (memWe) begin
      mem[memAddr] <= memWd;
    end
  end

  // outputs straight from the state register
  assign link.callReady = s_r.ready;
  assign link.callDone = s_r.done;
  assign link.retStatus = s_r.stat;
  assign link.retSecond = s_r.sec;
  assign link.irqPulse = s_r.irq;
  assign memPeekData = s_r.peek;
  assign txStart = s_r.txStart;
  assign txLen = s_r.txLen;
endmodule

// ---- hw/ebd_pkg.sv ----
/*
  ebd_pkg: shared constants for the ethernet buffer dma call engine and
  its register front end.
  assumes: both ends run on one 50 MHz clock, sys_clk, reset resetn.
*/
package ebd_pkg;
  // -------------------------------------------------------------------
  // memory layout (word addressed, top address bit picks buffer ram)
  // -------------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int MEM_WORDS = 128;
  localparam int BUF_SEL_BIT = 6;
  localparam logic [13:0] MEM_END = 14'h0080;

  // -------------------------------------------------------------------
  // call codes and return word layout
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_TX_START = 3'h0,
    FN_COPY = 3'h1,
    FN_FILL = 3'h2,
    FN_IBDMA = 3'h3,
    FN_TXBUF = 3'h4,
    FN_TXRES = 3'h5
  } ebd_func_t;
  localparam int DONE_BIT = 29;
  localparam int PEND_BIT = 8;
  localparam logic [1:0] RC_OK = 2'h0;
  localparam logic [1:0] RC_INVALID = 2'h2;
  localparam logic [1:0] RC_NOBUF = 2'h3;

  // -------------------------------------------------------------------
  // limits
  // -------------------------------------------------------------------
  localparam logic [31:0] TX_MIN_BYTES = 32'h0000_0001;
  localparam logic [31:0] TX_MAX_BYTES = 32'h0000_0800;
  localparam logic [31:0] FILL_MIN_WORDS = 32'h0000_0004;
  localparam logic [2:0] TXQ_DEPTH = 3'h4;
  localparam logic [2:0] TXBUF_COUNT = 3'h4;
  localparam logic [31:0] TXBUF_BASE = 32'h0000_4000;
  localparam logic [31:0] TXBUF_BYTES = 32'h0000_0800;

  // -------------------------------------------------------------------
  // interrupt bits and apb register offsets
  // -------------------------------------------------------------------
  localparam int IRQ_W = 6;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_MGMT = 1;
  localparam int IRQ_PAUSE = 2;
  localparam int IRQ_IBDONE = 3;
  localparam int IRQ_IBERR = 4;
  localparam int IRQ_CALL = 5;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ARG0 = 8'h04;
  localparam logic [7:0] OFF_ARG3 = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_SEC = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFF_BUSY = 8'h24;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;
endpackage

// ---- hw/ebd_call_if.sv ----
/*
  ebd_call_if: call and answer wires between the call issuer and the
  call engine.
  assumes: both ends share sys_clk; the bench joins them.
*/
`timescale 1ns/1ps
interface ebd_call_if;
  logic callValid;
  logic [2:0] callFunc;
  logic [3:0][31:0] callArg;
  logic callReady;
  logic callDone;
  logic [31:0] retStatus;
  logic [31:0] retSecond;
  logic [4:0] irqPulse;

  modport dev(
    input callValid, callFunc, callArg,
    output callReady, callDone, retStatus, retSecond, irqPulse
  );
  modport host(
    output callValid, callFunc, callArg,
    input callReady, callDone, retStatus, retSecond, irqPulse
  );
endinterface

// ---- hw/ebd_apb_host.sv ----
/*
  ebd_apb_host: apb register front end that issues engine calls and
  gathers engine events into masked sticky interrupts.
  assumes: apb master on sys_clk; engine on the far side of the link.
*/
`timescale 1ns/1ps
module ebd_apb_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // call link
  ebd_call_if.host link
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic callValid;
    logic [2:0] func;
    logic [3:0][31:0] args;
    logic [31:0] stat;
    logic [31:0] sec;
    logic busy;
    logic [ebd_pkg::IRQ_W-1:0] irqStat;
    logic [ebd_pkg::IRQ_W-1:0] irqMask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } ebd_host_s_t;

  ebd_host_s_t s_r, s_nxt;

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    logic [ebd_pkg::IRQ_W-1:0] set, clr;
    logic mapped, wr;
    logic [31:0] len;
    s_nxt = s_r;
    set = {1'b0, link.irqPulse};
    clr = '0;
    len = s_r.args[2];
    mapped = paddr <= ebd_pkg::OFF_BUSY && paddr[1:0] == 2'h0;
    // one wait state: read data is registered on the same edge that raises pready
    s_nxt.pready = psel && penable && !s_r.pready;
    wr = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
    if (psel && penable && !s_r.pready) begin
      s_nxt.pslverr = !mapped;
      case (paddr)
        ebd_pkg::OFF_CMD: s_nxt.prdata = {29'h0000_0000, s_r.func};
        ebd_pkg::OFF_STAT: s_nxt.prdata = s_r.stat;
        ebd_pkg::OFF_SEC: s_nxt.prdata = s_r.sec;
        ebd_pkg::OFF_IRQ_STAT: s_nxt.prdata = 32'(s_r.irqStat);
        ebd_pkg::OFF_IRQ_MASK: s_nxt.prdata = 32'(s_r.irqMask);
        ebd_pkg::OFF_BUSY: s_nxt.prdata = {31'h0000_0000, s_r.busy};
        default: s_nxt.prdata = (mapped && paddr >= ebd_pkg::OFF_ARG0) ?
          s_r.args[paddr[3:2] - 2'h1] : 32'h0000_0000;
      endcase
    end else if (!s_r.pready) begin
      s_nxt.pslverr = 1'b0;
    end
    if (s_r.pready) begin
      s_nxt.pslverr = 1'b0;
    end
    // writes land on the completing edge only
    if (wr) begin
      if (paddr == ebd_pkg::OFF_CMD && !s_r.busy) begin
        s_nxt.func = pwdata[2:0];
        if ((pwdata[2:0] == ebd_pkg::FN_TX_START &&
             (len < ebd_pkg::TX_MIN_BYTES || len > ebd_pkg::TX_MAX_BYTES)) ||
            (pwdata[2:0] == ebd_pkg::FN_FILL && len < ebd_pkg::FILL_MIN_WORDS)) begin
          s_nxt.stat = {2'h0, 1'b0, 27'h000_0000, ebd_pkg::RC_INVALID};
          set[ebd_pkg::IRQ_CALL] = 1'b1;
        end else begin
          s_nxt.callValid = 1'b1;
          s_nxt.busy = 1'b1;
        end
      end
      if (paddr >= ebd_pkg::OFF_ARG0 && paddr <= ebd_pkg::OFF_ARG3) begin
        s_nxt.args[paddr[3:2] - 2'h1] = pwdata;
      end
      if (paddr == ebd_pkg::OFF_IRQ_STAT) begin
        clr = pwdata[ebd_pkg::IRQ_W-1:0];
      end
      if (paddr == ebd_pkg::OFF_IRQ_MASK) begin
        s_nxt.irqMask = pwdata[ebd_pkg::IRQ_W-1:0];
      end
    end
    if (s_r.callValid && link.callReady) begin
      s_nxt.callValid = 1'b0;
    end
    // every engine answer; an inter-buffer call answers early and its end comes as an event
    if (link.callDone) begin
      s_nxt.stat = link.retStatus;
      s_nxt.sec = link.retSecond;
      s_nxt.busy = 1'b0;
      set[ebd_pkg::IRQ_CALL] = 1'b1;
    end
    // set wins over a write-one clear in the same cycle
    s_nxt.irqStat = (s_r.irqStat & ~clr) | set;
    s_nxt.irq = |(s_nxt.irqStat & s_nxt.irqMask);
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.irqStat <= ebd_pkg::IRQ_RST;
      s_r.irqMask <= ebd_pkg::IRQ_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.callValid = s_r.callValid;
  assign link.callFunc = s_r.func;
  assign link.callArg = s_r.args;
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq = s_r.irq;
endmodule

// ---- verification/ebd_call_monitor.sv ----
/*
  ebd_call_monitor: assertions on the call link between front end and engine.
  assumes: the bench instantiates it beside the link, on sys_clk and resetn.
*/
`timescale 1ns/1ps
module ebd_call_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // call link
  input wire logic callValid,
  input wire logic [2:0] callFunc,
  input wire logic [3:0][31:0] callArg,
  input wire logic callReady,
  input wire logic callDone,
  input wire logic [31:0] retStatus,
  input wire logic [31:0] retSecond,
  input wire logic [4:0] irqPulse
);
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------------
  // call in flight
  // ---------------------------------------------------------------------
  logic [2:0] fnR;
  logic [31:0] srcR, dstR, lenR, cnt;
  // arguments kept at the take edge, so the answer is judged by its own call
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fnR <= 3'h0;
      srcR <= 32'h0000_0000;
      dstR <= 32'h0000_0000;
      lenR <= 32'h0000_0000;
      cnt <= 32'h0000_0000;
    end else if (callValid && callReady) begin
      fnR <= callFunc;
      srcR <= callArg[0];
      dstR <= callArg[1];
      lenR <= callArg[2];
      cnt <= 32'h0000_0001;
    end else begin
      cnt <= cnt + 32'h0000_0001; // wraps only after a very long idle spell
    end
  end
  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  sequence s_ib_take;
    callValid && callReady && callFunc == ebd_pkg::FN_IBDMA;
  endsequence
  sequence s_answer(logic [2:0] f);
    callDone && fnR == f;
  endsequence
  sequence s_ok_answer(logic [2:0] f);
    callDone && fnR == f && retStatus[1:0] == ebd_pkg::RC_OK;
  endsequence
  a_tx_len_range: assert property (callValid && callFunc == ebd_pkg::FN_TX_START |->
    callArg[2] >= ebd_pkg::TX_MIN_BYTES && callArg[2] <= ebd_pkg::TX_MAX_BYTES)
    else $error("tx start call outside length range");
  a_copy_done_late: assert property (s_ok_answer(ebd_pkg::FN_COPY) |-> cnt > lenR)
    else $error("copy answered before all words moved");
  a_fill_done_late: assert property (s_ok_answer(ebd_pkg::FN_FILL) |-> cnt > lenR)
    else $error("fill answered before all words written");
  a_ib_answer_early: assert property (s_ib_take |-> ##[1:2] callDone)
    else $error("inter-buffer call not answered early");
  a_copy_regions: assert property (s_answer(ebd_pkg::FN_COPY) |->
    srcR[6] != dstR[6] || retStatus[1:0] == ebd_pkg::RC_INVALID)
    else $error("copy within one region accepted");
  a_ib_regions: assert property (s_answer(ebd_pkg::FN_IBDMA) |->
    srcR[6] == dstR[6] || retStatus[1:0] == ebd_pkg::RC_INVALID)
    else $error("mixed inter-buffer call accepted");
  a_fill_min_len: assert property (callValid && callFunc == ebd_pkg::FN_FILL |->
    callArg[2] >= ebd_pkg::FILL_MIN_WORDS)
    else $error("short fill reached the engine");
  a_status_done_bit: assert property (callDone |-> retStatus[29] == !retStatus[1])
    else $error("done bit disagrees with result code");
  a_txbuf_addr: assert property (s_ok_answer(ebd_pkg::FN_TXBUF) |->
    retSecond[10:0] == 11'h000 && retSecond >= ebd_pkg::TXBUF_BASE)
    else $error("granted buffer address misaligned");
  a_ib_err_alone: assert property (irqPulse[4] |-> !irqPulse[3] [*4])
    else $error("inter-buffer done beside error");
endmodule

// ---- verification/ethernet_buffer_dma_calls_bench.sv ----
/*
  ethernet_buffer_dma_calls_bench: apb driven test of the call engine and
  its register front end, joined by the call link.
  assumes: 50 MHz sys_clk; resetn low for four cycles at the start.
*/
`timescale 1ns/1ps
module ethernet_buffer_dma_calls_bench;
  // ---------------------------------------------------------------------
  // signals and parts
  // ---------------------------------------------------------------------
  localparam logic [31:0] OK_ST = 32'h2000_0000;
  localparam logic [31:0] BAD_ST = 32'h0000_0002;
  logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic txResValid = 0, mgmtDoneIn = 0, pauseDoneIn = 0, txBufRelease = 0, memLoadEn = 0;
  logic pready, pslverr, irq, err, txStart;
  logic [7:0] paddr = 8'h00, txResId = 8'h00, txResCode = 8'h00;
  logic [6:0] memLoadAddr = 7'h00, memPeekAddr = 7'h00;
  logic [31:0] pwdata = 32'h0000_0000, memLoadData = 32'h0000_0000;
  logic [31:0] prdata, memPeekData, rd;
  logic [11:0] txLen, lastLen;
  logic [31:0] txLens [4] = '{32'h0000_0001, 32'h0000_0800, 32'h0000_0000, 32'h0000_0801};
  int num_errors = 0, cmp_count = 0, starts = 0;
  ebd_call_if ebd_call_if_i();
  ebd_call_engine ebd_call_engine_i(.sys_clk(sys_clk), .resetn(resetn),
    .link(ebd_call_if_i.dev), .txResValid(txResValid), .txResId(txResId),
    .txResCode(txResCode), .mgmtDoneIn(mgmtDoneIn), .pauseDoneIn(pauseDoneIn),
    .txBufRelease(txBufRelease), .memLoadEn(memLoadEn), .memLoadAddr(memLoadAddr),
    .memLoadData(memLoadData), .memPeekAddr(memPeekAddr), .memPeekData(memPeekData),
    .txStart(txStart), .txLen(txLen));
  ebd_apb_host ebd_apb_host_i(.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(ebd_call_if_i.host));
  ebd_call_monitor ebd_call_monitor_i(.sys_clk(sys_clk), .resetn(resetn),
    .callValid(ebd_call_if_i.callValid), .callFunc(ebd_call_if_i.callFunc),
    .callArg(ebd_call_if_i.callArg), .callReady(ebd_call_if_i.callReady),
    .callDone(ebd_call_if_i.callDone), .retStatus(ebd_call_if_i.retStatus),
    .retSecond(ebd_call_if_i.retSecond), .irqPulse(ebd_call_if_i.irqPulse));
  // free running clock
  initial forever #10 sys_clk = ~sys_clk;
  // tx start pulses, counted to prove refused lengths never start the mac
  always @(posedge sys_clk) if (txStart === 1'b1) begin
    starts++;
    lastLen <= txLen;
  end
  // watchdog, far beyond the fewer than a thousand cycles the tests need
  initial begin
    #1_000_000;
    num_errors++;
    stop_test();
  end
  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(0, a, 0);
    chk(nm, e, rd);
  endtask
  // a call through the front end, then its status against e
  task automatic call(input logic [2:0] f, input logic [31:0] s, t, l, p, e);
    int n;
    apb(1, ebd_pkg::OFF_ARG0, s);
    apb(1, 8'h08, t);
    apb(1, 8'h0C, l);
    apb(1, ebd_pkg::OFF_ARG3, p);
    apb(1, ebd_pkg::OFF_CMD, {29'h0, f});
    n = 0;
    do begin
      apb(0, ebd_pkg::OFF_BUSY, 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    if (n >= 300) num_errors++;
    rdchk(ebd_pkg::OFF_STAT, e, "call status");
  endtask
  task automatic waitirq(input int b);
    int n;
    n = 0;
    do begin
      apb(0, ebd_pkg::OFF_IRQ_STAT, 0);
      n++;
    end while (rd[b] !== 1'b1 && n < 100);
    chk("irq status bit", 1, rd[b]);
  endtask
  task automatic peek(input int a, input logic [31:0] e);
    @(posedge sys_clk);
    memPeekAddr <= 7'(a);
    repeat (2) @(posedge sys_clk);
    chk("memory word", e, memPeekData);
  endtask
  // ---------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1;
    rdchk(ebd_pkg::OFF_IRQ_MASK, 0, "irq mask");
    rdchk(ebd_pkg::OFF_BUSY, 0, "busy");
    apb(0, 8'h28, 0);
    chk("unmapped error", 1, err);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      memLoadEn <= 1;
      memLoadAddr <= 7'(i);
      memLoadData <= 32'h1111_0000 + i;
      @(posedge sys_clk);
      memLoadEn <= 0;
    end
    call(ebd_pkg::FN_COPY, 0, 64, 4, 0, OK_ST);
    for (int i = 0; i < 4; i++) peek(64 + i, 32'h1111_0000 + i);
    call(ebd_pkg::FN_COPY, 64, 70, 2, 0, BAD_ST);
    call(ebd_pkg::FN_COPY, 0, 8, 2, 0, BAD_ST);
    call(ebd_pkg::FN_FILL, 0, 8, 4, 32'hA5A5_5A5A, OK_ST);
    for (int i = 0; i < 4; i++) peek(8 + i, 32'hA5A5_5A5A);
    call(ebd_pkg::FN_FILL, 0, 8, 3, 32'h0000_0000, BAD_ST);
    peek(8, 32'hA5A5_5A5A);
    call(ebd_pkg::FN_IBDMA, 64, 80, 4, 0, OK_ST);
    waitirq(ebd_pkg::IRQ_IBDONE);
    for (int i = 0; i < 4; i++) peek(80 + i, 32'h1111_0000 + i);
    apb(1, ebd_pkg::OFF_IRQ_STAT, 32'h0000_003F);
    call(ebd_pkg::FN_IBDMA, 0, 20, 2, 0, OK_ST);
    waitirq(ebd_pkg::IRQ_IBDONE);
    peek(21, 32'h1111_0001);
    call(ebd_pkg::FN_IBDMA, 0, 64, 2, 0, BAD_ST);
    apb(1, ebd_pkg::OFF_IRQ_STAT, 32'h0000_003F);
    call(ebd_pkg::FN_IBDMA, 126, 100, 4, 0, OK_ST);
    waitirq(ebd_pkg::IRQ_IBERR);
    chk("ib done beside error", 0, rd[ebd_pkg::IRQ_IBDONE]);
    // event bits stick, mask gates irq, write of one clears
    apb(1, ebd_pkg::OFF_IRQ_STAT, 32'h0000_003F);
    @(posedge sys_clk) mgmtDoneIn <= 1;
    @(posedge sys_clk) mgmtDoneIn <= 0;
    pauseDoneIn <= 1;
    @(posedge sys_clk) pauseDoneIn <= 0;
    rdchk(ebd_pkg::OFF_IRQ_STAT, 32'h0000_0006, "irq status");
    chk("irq masked", 0, irq);
    apb(1, ebd_pkg::OFF_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    chk("irq raised", 1, irq);
    apb(1, ebd_pkg::OFF_IRQ_STAT, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 0, irq);
    rdchk(ebd_pkg::OFF_IRQ_STAT, 32'h0000_0004, "irq status");
    for (int i = 0; i < 4; i++) call(ebd_pkg::FN_TX_START, 0, 0, txLens[i], 0, (i < 2) ? OK_ST : BAD_ST);
    chk("tx starts", 2, starts);
    chk("tx length", 32'h0000_0800, {20'h0, lastLen});
    for (int i = 0; i < 4; i++) begin
      call(ebd_pkg::FN_TXBUF, 0, 0, 0, 0, OK_ST);
      rdchk(ebd_pkg::OFF_SEC, 32'h0000_4000 + i * 32'h0000_0800, "buffer address");
    end
    call(ebd_pkg::FN_TXBUF, 0, 0, 0, 0, 32'h0000_0003);
    @(posedge sys_clk) txBufRelease <= 1;
    @(posedge sys_clk) txBufRelease <= 0;
    call(ebd_pkg::FN_TXBUF, 0, 0, 0, 0, OK_ST);
    // five results into four places: the first is lost
    for (int i = 1; i < 6; i++) begin
      @(posedge sys_clk);
      txResValid <= 1;
      txResId <= 8'(i);
      txResCode <= 8'(8'h10 + i);
      @(posedge sys_clk) txResValid <= 0;
    end
    waitirq(ebd_pkg::IRQ_OVF);
    for (int i = 2; i < 6; i++) begin
      call(ebd_pkg::FN_TXRES, 0, 0, 0, 0, (i < 5) ? 32'h2000_0100 : OK_ST);
      rdchk(ebd_pkg::OFF_SEC, {16'h0, 8'(i), 8'(8'h10 + i)}, "tx result");
    end
    call(ebd_pkg::FN_TXRES, 0, 0, 0, 0, OK_ST);
    rdchk(ebd_pkg::OFF_SEC, 32'h0000_0000, "empty result");
    stop_test();
  end
endmodule
